// file: inc/aps_regs.vh
// Register indices, field positions, reset values and timing constants
`ifndef APS_REGS_VH
`define APS_REGS_VH

// ============================================================
// Register indices (word addresses on the register port)
`define APS_IDX_W 11
`define APS_IDX_ANALOG_CFG 11'h523
`define APS_IDX_SYS_CFG 11'h530
`define APS_IDX_LOW_POWER 11'h533
`define APS_IDX_STATUS 11'h538
`define APS_IDX_PART_ID 11'h539
`define APS_IDX_OVERDRIVE 11'h53a

// ============================================================
// Low power configuration fields
`define APS_LP_WAKE_EN 0
`define APS_LP_THR_HI 2
`define APS_LP_THR_LO 1
`define APS_LP_MODE_HI 5
`define APS_LP_MODE_LO 4
`define APS_LP_TMO_HI 11
`define APS_LP_TMO_LO 8
`define APS_LP_ADC_HI 23
`define APS_LP_ADC_LO 12
`define APS_LP_FORCE_LO 24
`define APS_LP_RESET 32'h00000000
`define APS_LP_USED 32'hfffff837

// Low power mode codes
`define APS_MODE_NORMAL 2'h0
`define APS_MODE_ANALOG 2'h1
`define APS_MODE_ADC 2'h2
`define APS_MODE_DIGITAL 2'h3

// ============================================================
// System configuration fields
`define APS_SC_ADDR_HI 6
`define APS_SC_CUSTOM 8
`define APS_SC_PRESET_SRC 9
`define APS_SC_PRESET_HI 11
`define APS_SC_PRESET_LO 10
`define APS_SC_RESET 32'h00000030
`define APS_SC_USED 32'h00000f7f
`define APS_DEFAULT_ADDR 7'h30

// Analog configuration fields
`define APS_AC_GAIN_HI 1
`define APS_AC_GAIN_LO 0
`define APS_AC_PARALLEL 2
`define APS_AC_RESET 32'h00000000
`define APS_AC_USED 32'h00000007

// ============================================================
// Timing: tick period in microseconds and idle timeout table in milliseconds
`define APS_CLK_HZ 10000000
`define APS_TICK_US 1000
`define APS_TMO_W 18
`define APS_TMO_0 18'h0000a
`define APS_TMO_1 18'h00014
`define APS_TMO_2 18'h00032
`define APS_TMO_3 18'h00064
`define APS_TMO_4 18'h000c8
`define APS_TMO_5 18'h001f4
`define APS_TMO_6 18'h003e8
`define APS_TMO_7 18'h007d0
`define APS_TMO_8 18'h01388
`define APS_TMO_9 18'h02710
`define APS_TMO_10 18'h04e20
`define APS_TMO_11 18'h0c350
`define APS_TMO_12 18'h0ea60
`define APS_TMO_13 18'h13880
`define APS_TMO_14 18'h186a0
`define APS_TMO_15 18'h30d40

`endif

// file: design/aps_idle_timer.v
// Idle timeout timer counting millisecond ticks of silence
`timescale 1ns/1ps
`include "aps_regs.vh"
module aps_idle_timer #(
  parameter CYC_PER_TICK = 10000,
  parameter PRE_W = 14
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_run,
  input wire i_restart,
  input wire [3:0] i_sel,
  output wire o_expired
);
  reg [PRE_W-1:0] pre_ff;
  reg [`APS_TMO_W-1:0] cnt_ff;
  reg expired_ff;
  reg [`APS_TMO_W-1:0] limit;
  wire tick;

  // ============================================================
  // Timeout code to length in ticks
  always @*
  begin
    case (i_sel)
      4'h0: limit = `APS_TMO_0;
      4'h1: limit = `APS_TMO_1;
      4'h2: limit = `APS_TMO_2;
      4'h3: limit = `APS_TMO_3;
      4'h4: limit = `APS_TMO_4;
      4'h5: limit = `APS_TMO_5;
      4'h6: limit = `APS_TMO_6;
      4'h7: limit = `APS_TMO_7;
      4'h8: limit = `APS_TMO_8;
      4'h9: limit = `APS_TMO_9;
      4'ha: limit = `APS_TMO_10;
      4'hb: limit = `APS_TMO_11;
      4'hc: limit = `APS_TMO_12;
      4'hd: limit = `APS_TMO_13;
      4'he: limit = `APS_TMO_14;
      default: limit = `APS_TMO_15;
    endcase
  end

  assign tick =
    (pre_ff == CYC_PER_TICK[PRE_W-1:0] - {{(PRE_W-1){1'b0}}, 1'b1});

  // ============================================================
  // Prescaler and silence counter; restart clears both
  always @(posedge i_clk)
  begin
    if (i_srst || i_restart || !i_run)
    begin
      pre_ff <= {PRE_W{1'b0}}; // [R23]
      cnt_ff <= {`APS_TMO_W{1'b0}};
      expired_ff <= 1'b0;
    end
    else if (!expired_ff)
    begin
      if (tick)
      begin
        pre_ff <= {PRE_W{1'b0}};
        if (cnt_ff == limit - {{(`APS_TMO_W-1){1'b0}}, 1'b1})
          expired_ff <= 1'b1; // [R6]
        else
          cnt_ff <= cnt_ff + {{(`APS_TMO_W-1){1'b0}}, 1'b1};
      end
      else
        pre_ff <= pre_ff + {{(PRE_W-1){1'b0}}, 1'b1};
    end
  end

  assign o_expired = expired_ff;
endmodule

// file: design/aps_power_status_ctrl.v
// Power, wake-on-audio, status and configuration register bank
//
// Summary of operation
// R1 - Wake enable bit turns on automatic audio wake
// R2 - Threshold field picks 25 to 100 mV
// R3 - Mode field: normal, analog, converter, digital detect
// R4 - Analog mode compares input against chosen threshold
// R5 - Digital mode wakes on word select rising
// R6 - Timeout field sets silence delay, 10ms to 200s; only bit 11 of the field is kept on write, so 10ms or 5s
// R7 - Field holds converter output detection threshold
// R8 - Top eight bits force functions on regardless
// R9 - Memory test done and pass bits reported
// R10 - Status shows external memory detected
// R11 - Status shows bus error during memory read
// R12 - Status shows loader busy fetching memory contents
// R13 - Read-only fixed 32-bit part identifier
// R14 - Read-only integrator value and magnitude top
// R15 - Answer default address; alternate address programmable
// R16 - Parallel bit drives both outputs from OUT1
// R17 - Two-bit register field selects preamp gain
// R18 - Gain pins select gain; register overrides
// R19 - Preset source bit picks register or pins
// R20 - Coefficient source bit: preset or custom
// R21 - Preset mode ignores incoming serial audio
// R22 - Pin pair codes the four preset modes
// R23 - Detected audio restarts the idle timeout
// R24 - Writes to read-only registers are ignored
`timescale 1ns/1ps
`include "aps_regs.vh"
module aps_power_status_ctrl #(
  parameter CYC_PER_TICK = (`APS_CLK_HZ / 1000000) * `APS_TICK_US,
  parameter PRE_W = 14,
  parameter [31:0] PART_CODE = 32'h0000a5a5 // Arbitrary value
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [`APS_IDX_W-1:0] i_reg_idx,
  input wire [31:0] i_reg_wdata,
  output wire [31:0] o_reg_rdata,
  output wire o_reg_rvalid,
  input wire [6:0] i_bus_addr,
  output wire o_bus_addr_hit,
  input wire i_analog_above,
  input wire i_ws,
  input wire [11:0] i_adc_mag,
  input wire i_gain_pin_low,
  input wire i_gain_pin_high,
  input wire i_preset_pin_low,
  input wire i_preset_pin_high,
  input wire [1:0] i_memtest_done,
  input wire [1:0] i_memtest_pass,
  input wire [1:0] i_memtest_readback_enable,
  input wire i_eeprom_present,
  input wire i_eeprom_bus_error,
  input wire i_eeprom_loader_busy,
  input wire [15:0] i_mem_addr,
  input wire [23:0] i_overdrive_integrator,
  input wire [7:0] i_overdrive_integrator_top,
  output wire [1:0] o_wake_threshold_sel,
  output wire o_low_power,
  output wire o_out2_reset,
  output wire o_out1_reset,
  output wire o_out1_on,
  output wire o_out2_on,
  output wire o_reference_on,
  output wire o_synth_on,
  output wire o_right_converter_on,
  output wire o_left_converter_on,
  output wire [1:0] o_preamp_gain_sel,
  output wire o_parallel_mode,
  output wire [1:0] o_preset_mode,
  output wire o_custom_coeff,
  output wire o_i2s_rx_ignore
);
  localparam ST_ACTIVE = 1'b0;
  localparam ST_SLEEP = 1'b1;
  localparam NSYNC = 6;

  // ============================================================
  // Registers
  reg [31:0] low_power_config_ff;
  reg [31:0] system_configuration_ff;
  reg [31:0] analog_config_ff;
  reg gain_from_reg_ff;
  reg state_ff;
  reg nxt_state;
  reg ws_last_ff;
  reg [31:0] rdata_ff;
  reg rvalid_ff;
  reg [31:0] nxt_rdata;
  reg [NSYNC-1:0] sync1_ff;
  reg [NSYNC-1:0] sync2_ff;

  wire [NSYNC-1:0] async_in;
  wire analog_s;
  wire ws_s;
  wire [1:0] gain_pins_s;
  wire [1:0] preset_pins_s;
  wire wake_on_audio_enable;
  wire [1:0] low_power_select;
  wire [3:0] idle_timeout_sel;
  wire [11:0] adc_detect_threshold;
  wire [7:0] force_bits;
  wire auto_wake;
  wire ws_rise;
  reg detect;
  wire expired;
  wire sleeping;
  wire [31:0] status_word;

  // ============================================================
  // Pin synchronisers, two stages per asynchronous input
  // Gain and preset pins are static straps; the extra latency
  // only delays their first use after reset
  assign async_in = {i_preset_pin_high, i_preset_pin_low,
                     i_gain_pin_high, i_gain_pin_low,
                     i_ws, i_analog_above};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1)
    begin : g_sync
      always @(posedge i_clk)
      begin
        if (i_srst)
        begin
          sync1_ff[g] <= 1'b0;
          sync2_ff[g] <= 1'b0;
        end
        else
        begin
          sync1_ff[g] <= async_in[g];
          sync2_ff[g] <= sync1_ff[g];
        end
      end
    end
  endgenerate

  assign analog_s = sync2_ff[0];
  assign ws_s = sync2_ff[1];
  assign gain_pins_s = sync2_ff[3:2];
  assign preset_pins_s = sync2_ff[5:4];

  // ============================================================
  // Field extraction from the low power register
  assign wake_on_audio_enable = low_power_config_ff[`APS_LP_WAKE_EN];
  assign low_power_select =
    low_power_config_ff[`APS_LP_MODE_HI:`APS_LP_MODE_LO];
  assign idle_timeout_sel =
    low_power_config_ff[`APS_LP_TMO_HI:`APS_LP_TMO_LO];
  assign adc_detect_threshold =
    low_power_config_ff[`APS_LP_ADC_HI:`APS_LP_ADC_LO]; // [R7]
  assign force_bits = low_power_config_ff[31:`APS_LP_FORCE_LO];

  // Threshold code goes straight to the analog comparator
  assign o_wake_threshold_sel =
    low_power_config_ff[`APS_LP_THR_HI:`APS_LP_THR_LO]; // [R2]

  // Automatic wake only with enable set and a detect mode chosen
  assign auto_wake = wake_on_audio_enable &&
                     (low_power_select != `APS_MODE_NORMAL); // [R1] [R3]

  // ============================================================
  // Word select edge detector on the synchronised level
  always @(posedge i_clk)
  begin
    if (i_srst)
      ws_last_ff <= 1'b0;
    else
      ws_last_ff <= ws_s;
  end

  assign ws_rise = ws_s && !ws_last_ff;

  // ============================================================
  // Audio presence per detect mode
  // Mode 00 reports audio always, so the timer never runs
  always @*
  begin
    case (low_power_select)
      `APS_MODE_ANALOG: detect = analog_s; // [R4]
      `APS_MODE_ADC: detect = (i_adc_mag >= adc_detect_threshold); // [R7]
      `APS_MODE_DIGITAL: detect = ws_rise; // [R5]
      default: detect = 1'b1; // [R3]
    endcase
  end

  // ============================================================
  // Silence timer, restarted by every detection
  aps_idle_timer #(
    .CYC_PER_TICK(CYC_PER_TICK),
    .PRE_W(PRE_W)
  ) u_timer (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_run(auto_wake && (state_ff == ST_ACTIVE)),
    .i_restart(detect), // [R23]
    .i_sel(idle_timeout_sel), // [R6]
    .o_expired(expired)
  );

  // ============================================================
  // Wake state machine
  // Wake needs no timer; a single detect cycle is enough
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_ACTIVE:
      begin
        if (auto_wake && !detect && expired)
          nxt_state = ST_SLEEP; // [R6]
      end
      ST_SLEEP:
      begin
        if (!auto_wake || detect)
          nxt_state = ST_ACTIVE; // [R1] [R4] [R5]
      end
      default: nxt_state = ST_ACTIVE;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (i_srst)
      state_ff <= ST_ACTIVE;
    else
      state_ff <= nxt_state;
  end

  assign sleeping = (state_ff == ST_SLEEP);
  assign o_low_power = sleeping;

  // ============================================================
  // Power controls with per-function force overrides
  assign o_out2_reset = sleeping | force_bits[0]; // [R8]
  assign o_out1_reset = sleeping | force_bits[1]; // [R8]
  assign o_out1_on = !sleeping | force_bits[2]; // [R8]
  assign o_out2_on = !sleeping | force_bits[3]; // [R8]
  assign o_reference_on = !sleeping | force_bits[4]; // [R8]
  assign o_synth_on = !sleeping | force_bits[5]; // [R8]
  assign o_right_converter_on = !sleeping | force_bits[6]; // [R8]
  assign o_left_converter_on = !sleeping | force_bits[7]; // [R8]

  // ============================================================
  // Writable registers; read-only indices have no write path
  // Unused bits are masked so reads show zero there
  // First analog write hands gain control to the register
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      low_power_config_ff <= `APS_LP_RESET;
      system_configuration_ff <= `APS_SC_RESET;
      analog_config_ff <= `APS_AC_RESET;
      gain_from_reg_ff <= 1'b0;
    end
    else if (i_reg_wr)
    begin
      case (i_reg_idx)
        `APS_IDX_LOW_POWER:
          low_power_config_ff <= i_reg_wdata & `APS_LP_USED;
        `APS_IDX_SYS_CFG:
          system_configuration_ff <= i_reg_wdata & `APS_SC_USED; // [R15]
        `APS_IDX_ANALOG_CFG:
        begin
          analog_config_ff <= i_reg_wdata & `APS_AC_USED;
          gain_from_reg_ff <= 1'b1; // [R18]
        end
        default: gain_from_reg_ff <= gain_from_reg_ff; // [R24]
      endcase
    end
  end

  // ============================================================
  // Bus address match: fixed default or programmed alternate
  assign o_bus_addr_hit = (i_bus_addr == `APS_DEFAULT_ADDR) ||
    (i_bus_addr == system_configuration_ff[`APS_SC_ADDR_HI:0]); // [R15]

  // ============================================================
  // Analog and preset selection
  assign o_preamp_gain_sel = gain_from_reg_ff ?
    analog_config_ff[`APS_AC_GAIN_HI:`APS_AC_GAIN_LO] : // [R17]
    gain_pins_s; // [R18]
  assign o_parallel_mode = analog_config_ff[`APS_AC_PARALLEL]; // [R16]
  assign o_preset_mode = system_configuration_ff[`APS_SC_PRESET_SRC] ?
    system_configuration_ff[`APS_SC_PRESET_HI:`APS_SC_PRESET_LO] :
    preset_pins_s; // [R19] [R22]
  assign o_custom_coeff = system_configuration_ff[`APS_SC_CUSTOM]; // [R20]
  assign o_i2s_rx_ignore = !o_custom_coeff; // [R21]

  // ============================================================
  // Status word assembly
  assign status_word = {i_mem_addr,
                        4'h0,
                        i_eeprom_loader_busy, // [R12]
                        i_eeprom_bus_error, // [R11]
                        i_eeprom_present, // [R10]
                        3'h0,
                        i_memtest_readback_enable,
                        i_memtest_pass, // [R9]
                        i_memtest_done}; // [R9]

  // ============================================================
  // Read mux; unmapped indices read zero
  // Status and readback inputs are shown live, not latched
  always @*
  begin
    case (i_reg_idx)
      `APS_IDX_LOW_POWER: nxt_rdata = low_power_config_ff;
      `APS_IDX_SYS_CFG: nxt_rdata = system_configuration_ff;
      `APS_IDX_ANALOG_CFG: nxt_rdata = analog_config_ff;
      `APS_IDX_STATUS: nxt_rdata = status_word;
      `APS_IDX_PART_ID: nxt_rdata = PART_CODE; // [R13]
      `APS_IDX_OVERDRIVE: nxt_rdata = {i_overdrive_integrator_top,
                                       i_overdrive_integrator}; // [R14]
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // Read data register, valid one cycle after the strobe
  // Data hold until the next read, so a slow host can fetch late
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rdata_ff <= 32'h00000000;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= i_reg_rd;
      if (i_reg_rd)
        rdata_ff <= nxt_rdata;
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_reg_rvalid = rvalid_ff;
endmodule

// file: tb/aps_psc_monitor.sv
// Concurrent checks on the power and status register bank ports
`timescale 1ns/1ps
`include "aps_regs.vh"
module aps_psc_monitor #(
  parameter [31:0] PART_CODE = 32'h0
) (
  input logic i_clk,
  input logic i_srst,
  input logic i_reg_wr,
  input logic i_reg_rd,
  input logic [10:0] i_reg_idx,
  input logic [31:0] i_reg_wdata,
  input logic [31:0] o_reg_rdata,
  input logic o_reg_rvalid,
  input logic [6:0] i_bus_addr,
  input logic o_bus_addr_hit,
  input logic i_ws,
  input logic [23:0] i_overdrive_integrator,
  input logic [7:0] i_overdrive_integrator_top,
  input logic [1:0] o_wake_threshold_sel,
  input logic o_low_power,
  input logic o_out2_reset,
  input logic o_out1_on,
  input logic o_left_converter_on,
  input logic o_custom_coeff,
  input logic o_i2s_rx_ignore
);
  logic [31:0] lp_ff;
  wire lp_wr = i_reg_wr && (i_reg_idx == `APS_IDX_LOW_POWER);
  wire [31:0] nxt_lp = lp_wr ? (i_reg_wdata & `APS_LP_USED) : lp_ff;
  wire rd_part = i_reg_rd && (i_reg_idx == `APS_IDX_PART_ID);
  wire rd_ovd = i_reg_rd && (i_reg_idx == `APS_IDX_OVERDRIVE);

  // ============================================================
  // Mirror of the low power register
  always @(posedge i_clk)
  begin
    if (i_srst)
      lp_ff <= 32'h0;
    else
      lp_ff <= nxt_lp;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  // ============================================================
  // Wake steps: armed word select rise, then active state
  sequence s_ws_rise;
    $rose(i_ws) && lp_ff[0] && (lp_ff[5:4] == 2'h3);
  endsequence
  sequence s_awake;
    1'b1 ##[1:6] !o_low_power;
  endsequence

  a_ws_wakes: assert property (s_ws_rise |-> s_awake)
    else $error("word select rise did not wake");
  a_sleep_armed: assert property ($rose(o_low_power) |->
    lp_ff[0] && lp_ff[5:4] != 2'h0)
    else $error("sleep entered without wake mode");
  a_thr_follows: assert property (o_wake_threshold_sel == lp_ff[2:1])
    else $error("threshold output differs from register");
  a_force_left: assert property (lp_ff[31] |-> o_left_converter_on)
    else $error("forced converter not on");
  a_sleep_resets: assert property (o_low_power |-> o_out2_reset)
    else $error("output reset low in sleep");
  a_active_on: assert property (!o_low_power |-> o_out1_on)
    else $error("output off while active");
  a_part_read: assert property (rd_part |=> o_reg_rdata == PART_CODE)
    else $error("part code read wrong");
  a_ovd_read: assert property (rd_ovd |=> o_reg_rdata ==
    {$past(i_overdrive_integrator_top), $past(i_overdrive_integrator)})
    else $error("integrator readback wrong");
  a_default_addr: assert property (i_bus_addr == 7'h30 |->
    o_bus_addr_hit)
    else $error("default address missed");
  a_rom_ignore: assert property (o_i2s_rx_ignore == !o_custom_coeff)
    else $error("serial ignore not tied to preset mode");
endmodule

bind aps_power_status_ctrl aps_psc_monitor #(.PART_CODE(PART_CODE)) mon_i (
  .i_clk, .i_srst, .i_reg_wr, .i_reg_rd, .i_reg_idx, .i_reg_wdata,
  .o_reg_rdata, .o_reg_rvalid, .i_bus_addr, .o_bus_addr_hit, .i_ws,
  .i_overdrive_integrator, .i_overdrive_integrator_top,
  .o_wake_threshold_sel, .o_low_power, .o_out2_reset, .o_out1_on,
  .o_left_converter_on, .o_custom_coeff, .o_i2s_rx_ignore
);

// file: tb/aps_host_model.sv
// Host controller model driving the register port
`timescale 1ns/1ps
module aps_host_model (
  input logic i_clk,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [10:0] o_reg_idx,
  output logic [31:0] o_reg_wdata,
  input logic [31:0] i_reg_rdata,
  input logic i_reg_rvalid
);
  // Idle bus at time zero
  initial
  begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_idx = 11'h0;
    o_reg_wdata = 32'h0;
  end

  // One write strobe per word; data inverted once released
  task wr(input logic [10:0] idx, input logic [31:0] d);
    @(posedge i_clk);
    o_reg_wr <= 1'b1;
    o_reg_idx <= idx;
    o_reg_wdata <= d;
    @(posedge i_clk);
    o_reg_wr <= 1'b0;
    o_reg_idx <= ~idx;
    o_reg_wdata <= ~d;
  endtask

  // Read strobe, then bounded wait for the data pulse
  task rd(input logic [10:0] idx, output logic [31:0] d, output logic ok);
    int k;
    @(posedge i_clk);
    o_reg_rd <= 1'b1;
    o_reg_idx <= idx;
    @(posedge i_clk);
    o_reg_rd <= 1'b0;
    o_reg_idx <= ~idx;
    k = 0;
    #1;
    while (i_reg_rvalid !== 1'b1 && k < 4)
    begin
      @(posedge i_clk);
      #1;
      k++;
    end
    ok = (k < 4);
    d = i_reg_rdata;
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the power and status register bank
`timescale 1ns/1ps
`include "aps_regs.vh"
module testbench;
  localparam [31:0] PCODE = 32'h0000c3c3; // Arbitrary value
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_reg_wr, i_reg_rd, o_reg_rvalid, o_bus_addr_hit, i_ws = 1'b0;
  logic [10:0] i_reg_idx;
  logic [31:0] i_reg_wdata, o_reg_rdata;
  logic [6:0] i_bus_addr = 7'h0;
  logic i_analog_above = 1'b1;
  logic [11:0] i_adc_mag = 12'h0;
  logic i_gain_pin_low = 1'b0, i_gain_pin_high = 1'b0;
  logic i_preset_pin_low = 1'b0, i_preset_pin_high = 1'b0;
  logic [1:0] i_memtest_done = 2'h2, i_memtest_pass = 2'h1;
  logic [1:0] i_memtest_readback_enable = 2'h3;
  logic i_eeprom_present = 1'b1, i_eeprom_bus_error = 1'b0;
  logic i_eeprom_loader_busy = 1'b1;
  logic [15:0] i_mem_addr = 16'h5a3c;
  logic [23:0] i_overdrive_integrator = 24'h123456;
  logic [7:0] i_overdrive_integrator_top = 8'h9a;
  logic [1:0] o_wake_threshold_sel, o_preamp_gain_sel, o_preset_mode;
  logic o_low_power, o_out2_reset, o_out1_reset, o_out1_on, o_out2_on;
  logic o_reference_on, o_synth_on, o_right_converter_on;
  logic o_left_converter_on, o_parallel_mode, o_custom_coeff;
  logic o_i2s_rx_ignore;
  logic [31:0] rdv;
  logic rok;
  int n_mismatch = 0;
  int num_checks = 0;
  wire [7:0] ctl = {o_out2_reset, o_out1_reset, o_out1_on, o_out2_on,
    o_reference_on, o_synth_on, o_right_converter_on, o_left_converter_on};

  // Clock of 100 ns period
  always #50 i_clk = ~i_clk;

  aps_power_status_ctrl #(.CYC_PER_TICK(4), .PART_CODE(PCODE))
    aps_power_status_ctrl_i (.i_clk, .i_srst, .i_reg_wr, .i_reg_rd,
    .i_reg_idx, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_bus_addr,
    .o_bus_addr_hit, .i_analog_above, .i_ws, .i_adc_mag, .i_gain_pin_low,
    .i_gain_pin_high, .i_preset_pin_low, .i_preset_pin_high,
    .i_memtest_done, .i_memtest_pass, .i_memtest_readback_enable,
    .i_eeprom_present, .i_eeprom_bus_error, .i_eeprom_loader_busy,
    .i_mem_addr, .i_overdrive_integrator, .i_overdrive_integrator_top,
    .o_wake_threshold_sel, .o_low_power, .o_out2_reset, .o_out1_reset,
    .o_out1_on, .o_out2_on, .o_reference_on, .o_synth_on,
    .o_right_converter_on, .o_left_converter_on, .o_preamp_gain_sel,
    .o_parallel_mode, .o_preset_mode, .o_custom_coeff, .o_i2s_rx_ignore);

  aps_host_model aps_host_model_i (.i_clk, .o_reg_wr(i_reg_wr),
    .o_reg_rd(i_reg_rd), .o_reg_idx(i_reg_idx), .o_reg_wdata(i_reg_wdata),
    .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid));

  // ============================================================
  // Verdict and shared checks
  task close_out;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask

  task rchk(input logic [10:0] idx, input logic [31:0] e);
    aps_host_model_i.rd(idx, rdv, rok);
    if (!rok)
    begin
      n_mismatch++;
      $display("[ERR] %0t no read answer", $time);
      close_out;
    end
    else
      chk(rdv, e);
  endtask

  // Bounded wait for the sleep flag to reach a level
  task wait_lp(input logic v, input int lim);
    int k;
    k = 0;
    #1;
    while (o_low_power !== v && k < lim)
    begin
      @(posedge i_clk);
      #1;
      k++;
    end
    chk(32'(o_low_power), 32'(v));
    if (o_low_power !== v)
      close_out;
  endtask

  task hold(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // ============================================================
  // Scenarios
  task t_regs;
    rchk(`APS_IDX_LOW_POWER, 32'h0);
    rchk(`APS_IDX_SYS_CFG, 32'h30);
    rchk(11'h100, 32'h0);
    chk(32'(ctl), 32'h3f);
    for (int i = 0; i < 2; i++)
    begin
      rchk(`APS_IDX_STATUS,
        i ? 32'ha5c30409 : 32'h5a3c0a36);
      rchk(`APS_IDX_PART_ID, PCODE);
      rchk(`APS_IDX_OVERDRIVE, i ? 32'h65edcba9 : 32'h9a123456);
      aps_host_model_i.wr(`APS_IDX_STATUS, 32'hffffffff);
      aps_host_model_i.wr(`APS_IDX_PART_ID, 32'hffffffff);
      aps_host_model_i.wr(`APS_IDX_OVERDRIVE, 32'hffffffff);
      {i_memtest_done, i_memtest_pass, i_memtest_readback_enable} <= 6'h18;
      {i_eeprom_present, i_eeprom_bus_error, i_eeprom_loader_busy} <= 3'h2;
      i_mem_addr <= 16'ha5c3;
      {i_overdrive_integrator_top, i_overdrive_integrator} <= 32'h65edcba9;
    end
  endtask

  task t_fields;
    aps_host_model_i.wr(`APS_IDX_LOW_POWER, 32'hffffffff);
    rchk(`APS_IDX_LOW_POWER, 32'hfffff837);
    for (int t = 0; t < 4; t++)
    begin
      aps_host_model_i.wr(`APS_IDX_LOW_POWER, 32'(t) << 1);
      #1;
      chk(32'(o_wake_threshold_sel), 32'(t));
    end
    aps_host_model_i.wr(`APS_IDX_LOW_POWER, 32'hff000000);
    #1;
    chk(32'(ctl), 32'hff);
  endtask

  task t_wake;
    aps_host_model_i.wr(`APS_IDX_LOW_POWER, 32'h30);
    hold(60);
    chk(32'(o_low_power), 32'h0);
    aps_host_model_i.wr(`APS_IDX_LOW_POWER, 32'h31);
    hold(30);
    chk(32'(o_low_power), 32'h0);
    wait_lp(1'b1, 30);
    chk(32'(ctl), 32'hc0);
    @(posedge i_clk) i_ws <= 1'b1;
    wait_lp(1'b0, 8);
    repeat (4)
    begin
      hold(15);
      @(posedge i_clk) i_ws <= 1'b0;
      hold(15);
      chk(32'(o_low_power), 32'h0);
      @(posedge i_clk) i_ws <= 1'b1;
    end
    aps_host_model_i.wr(`APS_IDX_LOW_POWER, 32'h11);
    hold(60);
    chk(32'(o_low_power), 32'h0);
    @(posedge i_clk) i_analog_above <= 1'b0;
    wait_lp(1'b1, 80);
    aps_host_model_i.wr(`APS_IDX_LOW_POWER, 32'h00100021);
    hold(60);
    chk(32'(o_low_power), 32'h1);
    @(posedge i_clk) i_adc_mag <= 12'h100;
    wait_lp(1'b0, 8);
    aps_host_model_i.wr(`APS_IDX_LOW_POWER, 32'h01);
    i_adc_mag <= 12'h0;
    hold(60);
    chk(32'(o_low_power), 32'h0);
  endtask

  task t_pins;
    chk({o_custom_coeff, o_i2s_rx_ignore}, 32'h1);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge i_clk) {i_gain_pin_high, i_gain_pin_low} <= 2'(c);
      {i_preset_pin_high, i_preset_pin_low} <= 2'(c);
      hold(4);
      chk(32'(o_preamp_gain_sel), 32'(c));
      chk(32'(o_preset_mode), 32'(c));
    end
    aps_host_model_i.wr(`APS_IDX_ANALOG_CFG, 32'h6);
    hold(5);
    chk({o_parallel_mode, o_preamp_gain_sel}, 32'h6);
    aps_host_model_i.wr(`APS_IDX_SYS_CFG, 32'hfffff745);
    rchk(`APS_IDX_SYS_CFG, 32'h745);
    chk({o_preset_mode, o_custom_coeff, o_i2s_rx_ignore},
      32'h6);
    for (int a = 0; a < 3; a++)
    begin
      @(posedge i_clk);
      i_bus_addr <= a == 0 ? 7'h30 : (a == 1 ? 7'h45 : 7'h31);
      hold(1);
      chk(32'(o_bus_addr_hit), a < 2);
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    t_regs;
    t_fields;
    t_wake;
    t_pins;
    close_out;
  end
endmodule
